// ---- rtl/dac_pkg.sv ----
// Constants and types for the codec root and function group verb unit.
package dac_pkg;
  localparam logic [11:0] VERB_GET_PARAM = 12'hf00;
  localparam logic [11:0] VERB_SET_POWER = 12'h705;
  localparam logic [11:0] VERB_GET_POWER = 12'hf05;
  localparam logic [11:0] VERB_SET_SUBSYS0 = 12'h720;
  localparam logic [11:0] VERB_GET_SUBSYS0 = 12'hf20;
  localparam logic [11:0] VERB_GET_SUBSYS3 = 12'hf23;
  localparam logic [11:0] VERB_SET_CLOCK = 12'h724;
  localparam logic [11:0] VERB_GET_CLOCK = 12'hf24;
  localparam logic [11:0] VERB_GET_CLK_ALT = 12'hf37;
  localparam logic [11:0] VERB_SET_VENDOR = 12'h781;
  localparam logic [11:0] VERB_GET_VENDOR = 12'hf81;
  localparam logic [11:0] VERB_GROUP_RESET = 12'h7ff;
  localparam logic [7:0]  NODE_ROOT   = 8'h00;
  localparam logic [7:0]  NODE_GROUP  = 8'h01;
  localparam logic [7:0]  NODE_VENDOR = 8'h0b;
  localparam logic [3:0]  NODE_FIRST_PIN = 4'h5;
  localparam logic [7:0]  PARAM_IDENT = 8'h00;
  localparam logic [7:0]  PARAM_REV   = 8'h02;
  localparam logic [7:0]  PARAM_CHILD = 8'h04;
  localparam logic [7:0]  PARAM_TYPE  = 8'h05;
  localparam logic [7:0]  PARAM_CAP   = 8'h08;
  localparam logic [7:0]  PARAM_POWER = 8'h0f;
  localparam logic [7:0]  PARAM_LINK  = 8'h16;
  localparam logic [31:0] REV_VALUE   = 32'h0010_0000;
  localparam logic [31:0] ROOT_CHILD  = 32'h0000_0001;
  localparam logic [31:0] GROUP_CHILD = 32'h0003_0007;
  localparam logic [31:0] GROUP_TYPE  = 32'h0000_0001;
  localparam logic [31:0] GROUP_CAP   = 32'h0000_0000;
  localparam logic [31:0] POWER_LEVELS = 32'hc000_0009;
  localparam logic [31:0] LINK_CAP    = 32'h0000_0018;
  localparam logic [31:0] PS_FIXED    = 32'h0000_0200;
  localparam int          PS_ACTUAL_LSB = 4;
  localparam logic [1:0]  PS_D0 = 2'h0;
  localparam logic [1:0]  PS_D3 = 2'h3;
  localparam logic [5:0]  CLOCK_RESET = 6'h10;
  localparam logic [7:0]  VENDOR_RESET = 8'h00;
  localparam int          VC_THREE = 0;
  localparam int          VC_MULTI = 1;
  localparam int          VC_WL_LSB = 2;
  localparam int          VC_FOURTH = 4;
  localparam int          VC_PORT_LSB = 6;
  localparam logic [1:0]  WL_ONE = 2'h1;
  localparam logic [1:0]  WL_TWO = 2'h2;
  localparam logic [2:0]  PINS_ONE = 3'h1;
  localparam logic [2:0]  PINS_THREE = 3'h3;
  localparam logic [2:0]  PINS_FOUR = 3'h4;

  typedef struct packed {
    logic [7:0]  node;
    logic [11:0] verb;
    logic [7:0]  payload;
  } dac_cmd_t;

  typedef struct packed {
    logic [2:0] pin_count;
    logic [1:0] port_select;
    logic [1:0] wl_count;
    logic [3:0] wl_first;
    logic       multistream;
    logic       any_map;
  } dac_map_t;
endpackage

// ---- rtl/dac_verb_unit.sv ----
// Verb decoder for the codec root node, function group and vendor widget.
module dac_verb_unit #(
  parameter logic [15:0] MAKER_CODE = 16'h1a2b,  // Arbitrary value.
  parameter logic [15:0] PART_CODE  = 16'h0c3d,  // Arbitrary value.
  parameter logic [31:0] SUBSYS_ID_RESET = 32'h1a2b_0001  // Arbitrary value.
) (
  input  wire logic            clk_i,          // Codec clock.
  input  wire logic            rst_n_i,        // Link reset, active low.
  input  wire logic            cmd_valid_i,    // Verb present this cycle.
  input  wire dac_pkg::dac_cmd_t cmd_i,        // Node, verb, payload.
  output logic                 rsp_valid_o,    // Response strobe.
  output logic [31:0]          rsp_data_o,     // Response word.
  output dac_pkg::dac_map_t    node_map_o,     // Exposed widget layout.
  output logic [1:0]           power_level_o,  // Actual power state.
  output logic [5:0]           clock_select_o, // Codec clock select, six bits as written.
  output logic [31:0]          subsystem_id_o  // Subsystem identifier.
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // True when the verb addresses the given node with the given code.
  function automatic logic hit(input dac_pkg::dac_cmd_t c,
                               input logic [7:0] node,
                               input logic [11:0] verb);
    hit = (c.node == node) && (c.verb == verb);
  endfunction

  // Widget layout implied by a vendor control value.
  function automatic dac_pkg::dac_map_t layout(input logic [7:0] v);
    dac_pkg::dac_map_t m;
    logic [1:0] wl;
    m = '0;
    wl = v[dac_pkg::VC_WL_LSB +: 2];
    m.port_select = v[dac_pkg::VC_PORT_LSB +: 2];
    m.multistream = v[dac_pkg::VC_THREE] & v[dac_pkg::VC_MULTI];
    m.pin_count = dac_pkg::PINS_ONE;
    if (v[dac_pkg::VC_THREE])
    begin
      m.pin_count = v[dac_pkg::VC_FOURTH] ? dac_pkg::PINS_FOUR
                                          : dac_pkg::PINS_THREE;
      // Three pins alone map 1:1; the others allow any-to-any.
      m.any_map = v[dac_pkg::VC_MULTI] | v[dac_pkg::VC_FOURTH];
    end
    // Wireless widgets follow the last pin widget.
    m.wl_first = dac_pkg::NODE_FIRST_PIN + {1'b0, m.pin_count};
    if (m.multistream && (wl == dac_pkg::WL_ONE || wl == dac_pkg::WL_TWO))
    begin
      m.wl_count = wl;
    end
    layout = m;
  endfunction

  logic       grp_reset;
  logic       set_power;
  logic       set_clock;
  logic       set_vendor;
  logic [7:0] pay;

  assign pay = cmd_i.payload;
  // Group reset acts only on the function group node.
  assign grp_reset = cmd_valid_i &&
    hit(cmd_i, dac_pkg::NODE_GROUP, dac_pkg::VERB_GROUP_RESET);
  assign set_power = cmd_valid_i &&
    hit(cmd_i, dac_pkg::NODE_GROUP, dac_pkg::VERB_SET_POWER);
  assign set_clock = cmd_valid_i &&
    hit(cmd_i, dac_pkg::NODE_GROUP, dac_pkg::VERB_SET_CLOCK);
  assign set_vendor = cmd_valid_i &&
    hit(cmd_i, dac_pkg::NODE_VENDOR, dac_pkg::VERB_SET_VENDOR);

  // ----------------------------------------------------------------
  // Stored controls
  // ----------------------------------------------------------------

  logic [7:0] vendor_q;
  logic [1:0] req_q;

  // Vendor control; the group reset returns it to the plain layout.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      vendor_q <= dac_pkg::VENDOR_RESET;
    else if (grp_reset)
      vendor_q <= dac_pkg::VENDOR_RESET;
    else if (set_vendor)
      vendor_q <= pay;
  end

  // Layout is registered so the map output comes from a flip-flop.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      node_map_o <= '0;
    else
      node_map_o <= layout(vendor_q);
  end

  // Requested state is echoed as written, reset to D3.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      req_q <= dac_pkg::PS_D3;
    else if (grp_reset)
      req_q <= dac_pkg::PS_D3;
    else if (set_power)
      req_q <= pay[1:0];
  end

  // Actual state moves only on a legal request or a group reset; D1 and D2 are unsupported,
  // so a stray code leaves the node where it was.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      power_level_o <= dac_pkg::PS_D3;
    else if (grp_reset)
      power_level_o <= dac_pkg::PS_D3;
    else if (set_power && (pay[1:0] == dac_pkg::PS_D0 ||
                           pay[1:0] == dac_pkg::PS_D3))
      power_level_o <= pay[1:0];
  end

  // Clock selection keeps the six selector bits; bits 7:6 are dropped.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      clock_select_o <= dac_pkg::CLOCK_RESET;
    else if (grp_reset)
      clock_select_o <= dac_pkg::CLOCK_RESET;
    else if (set_clock)
      clock_select_o <= pay[5:0];
  end

  // One byte lane of the identifier per set verb.
  for (genvar i = 0; i < 4; i++)
  begin : g_subsys
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
        subsystem_id_o[8*i +: 8] <= SUBSYS_ID_RESET[8*i +: 8];
      else if (grp_reset)
        subsystem_id_o[8*i +: 8] <= SUBSYS_ID_RESET[8*i +: 8];
      else if (cmd_valid_i && hit(cmd_i, dac_pkg::NODE_GROUP,
               dac_pkg::VERB_SET_SUBSYS0 + 12'(i)))
        subsystem_id_o[8*i +: 8] <= pay;
    end
  end

  // ----------------------------------------------------------------
  // Response
  // ----------------------------------------------------------------

  logic [31:0] rsp_d;
  logic [31:0] ps_report;

  assign ps_report = dac_pkg::PS_FIXED |
    (32'(power_level_o) << dac_pkg::PS_ACTUAL_LSB) | 32'(req_q);

  // Anything not decoded below answers zero, never stale data.
  always_comb
  begin
    rsp_d = '0;
    if (cmd_i.node == dac_pkg::NODE_ROOT)
    begin
      if (cmd_i.verb == dac_pkg::VERB_GET_PARAM)
      begin
        case (pay)
          dac_pkg::PARAM_IDENT: rsp_d = {MAKER_CODE, PART_CODE};
          dac_pkg::PARAM_REV:   rsp_d = dac_pkg::REV_VALUE;
          dac_pkg::PARAM_CHILD: rsp_d = dac_pkg::ROOT_CHILD;
          default:              rsp_d = '0;
        endcase
      end
    end
    else if (cmd_i.node == dac_pkg::NODE_GROUP)
    begin
      case (cmd_i.verb)
        dac_pkg::VERB_GET_PARAM:
        begin
          case (pay)
            dac_pkg::PARAM_CHILD: rsp_d = dac_pkg::GROUP_CHILD;
            dac_pkg::PARAM_TYPE:  rsp_d = dac_pkg::GROUP_TYPE;
            dac_pkg::PARAM_CAP:   rsp_d = dac_pkg::GROUP_CAP;
            dac_pkg::PARAM_POWER: rsp_d = dac_pkg::POWER_LEVELS;
            dac_pkg::PARAM_LINK:  rsp_d = dac_pkg::LINK_CAP;
            default:              rsp_d = '0;
          endcase
        end
        dac_pkg::VERB_GET_POWER: rsp_d = ps_report;
        dac_pkg::VERB_GET_CLOCK,
        dac_pkg::VERB_GET_CLK_ALT: rsp_d = 32'(clock_select_o);
        default:
        begin
          // All four identifier gets return the whole word.
          if (cmd_i.verb >= dac_pkg::VERB_GET_SUBSYS0 &&
              cmd_i.verb <= dac_pkg::VERB_GET_SUBSYS3)
            rsp_d = subsystem_id_o;
        end
      endcase
    end
    else if (cmd_i.node == dac_pkg::NODE_VENDOR)
    begin
      if (cmd_i.verb == dac_pkg::VERB_GET_VENDOR)
        rsp_d = {24'h0, vendor_q};
    end
  end

  // Every verb gets exactly one answer, one cycle later.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rsp_valid_o <= 1'b0;
      rsp_data_o  <= '0;
    end
    else
    begin
      rsp_valid_o <= cmd_valid_i;
      rsp_data_o  <= cmd_valid_i ? rsp_d : '0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  logic get_root;
  logic get_group;
  assign get_root = cmd_valid_i &&
    hit(cmd_i, dac_pkg::NODE_ROOT, dac_pkg::VERB_GET_PARAM);
  assign get_group = cmd_valid_i &&
    hit(cmd_i, dac_pkg::NODE_GROUP, dac_pkg::VERB_GET_PARAM);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_root_ident: assert property (
    get_root && pay == dac_pkg::PARAM_IDENT |=>
      rsp_valid_o && rsp_data_o == {MAKER_CODE, PART_CODE})
    else $error("identity answer wrong");

  a_root_rev: assert property (
    get_root && pay == dac_pkg::PARAM_REV |=> rsp_data_o == 32'h0010_0000)
    else $error("revision answer wrong");

  a_root_only: assert property (
    cmd_valid_i && cmd_i.node == dac_pkg::NODE_ROOT &&
    cmd_i.verb != dac_pkg::VERB_GET_PARAM |=> rsp_data_o == 32'h0)
    else $error("root answered a verb it lacks");

  a_group_params: assert property (
    get_group && pay == dac_pkg::PARAM_CHILD |=> rsp_data_o == 32'h0003_0007)
    else $error("group child count wrong");

  a_power_levels: assert property (
    get_group && pay == dac_pkg::PARAM_POWER |=> rsp_data_o == 32'hc000_0009)
    else $error("supported power states wrong");

  a_link_cap: assert property (
    get_group && pay == dac_pkg::PARAM_LINK |=>
      rsp_data_o[4:3] == 2'h3 && rsp_data_o[16] == 1'b0)
    else $error("link capability wrong");

  a_power_echo: assert property (
    set_power && pay[1:0] == 2'h0 ##1 !cmd_valid_i ##1
    cmd_valid_i && hit(cmd_i, dac_pkg::NODE_GROUP, dac_pkg::VERB_GET_POWER)
    |=> rsp_data_o == 32'h0000_0200)
    else $error("power report does not follow D0 request");

  a_power_bits: assert property (
    cmd_valid_i && hit(cmd_i, dac_pkg::NODE_GROUP, dac_pkg::VERB_GET_POWER)
    |=> rsp_data_o[10:8] == 3'h2)
    else $error("power report fixed bits wrong");

  a_clock_set: assert property (
    set_clock |=> clock_select_o == $past(pay[5:0]))
    else $error("clock select not stored");

  a_subsys_top: assert property (
    cmd_valid_i && hit(cmd_i, dac_pkg::NODE_GROUP, 12'h723) |=>
      subsystem_id_o[31:24] == $past(pay))
    else $error("identifier top byte not stored");

  a_group_reset: assert property (
    grp_reset |=> power_level_o == 2'h3 && clock_select_o == 6'h10)
    else $error("group reset left state");

  a_map_four_two: assert property (
    set_vendor && pay[4:0] == 5'h1b |=> ##1
      node_map_o.wl_first == 4'h9 && node_map_o.wl_count == 2'h2)
    else $error("four pins with two wireless misplaced");

  a_map_three_one: assert property (
    set_vendor && pay[4:0] == 5'h07 |=> ##1
      node_map_o.wl_first == 4'h8 && node_map_o.wl_count == 2'h1 &&
      node_map_o.pin_count == 3'h3)
    else $error("three pins with one wireless misplaced");

  a_root_child: assert property (
    get_root && pay == dac_pkg::PARAM_CHILD |=> rsp_data_o == 32'h0000_0001)
    else $error("root child count wrong");

  a_group_type: assert property (
    get_group && pay == dac_pkg::PARAM_TYPE |=> rsp_data_o == 32'h0000_0001)
    else $error("group type wrong");

  a_group_cap: assert property (
    get_group && pay == dac_pkg::PARAM_CAP |=> rsp_data_o == 32'h0)
    else $error("group capability wrong");

  a_clock_read: assert property (
    cmd_valid_i && cmd_i.node == dac_pkg::NODE_GROUP &&
    (cmd_i.verb == dac_pkg::VERB_GET_CLOCK ||
     cmd_i.verb == dac_pkg::VERB_GET_CLK_ALT) |=>
      rsp_data_o[31:6] == 26'h0 && rsp_data_o[5:0] == $past(clock_select_o))
    else $error("clock read wrong");

  a_idle_quiet: assert property (
    !cmd_valid_i |=> !rsp_valid_o && rsp_data_o == 32'h0)
    else $error("answer without a verb");

  a_every_answer: assert property (
    cmd_valid_i |=> rsp_valid_o)
    else $error("verb left unanswered");

  a_set_zero: assert property (
    cmd_valid_i && cmd_i.verb[11:8] == 4'h7 |=> rsp_data_o == 32'h0)
    else $error("set verb answered with data");

  a_power_legal: assert property (
    power_level_o == dac_pkg::PS_D0 || power_level_o == dac_pkg::PS_D3)
    else $error("actual power state illegal");

  a_subsys_low: assert property (
    cmd_valid_i && hit(cmd_i, dac_pkg::NODE_GROUP, dac_pkg::VERB_SET_SUBSYS0)
    |=> subsystem_id_o[7:0] == $past(pay))
    else $error("identifier low byte not stored");

  a_subsys_reset: assert property (
    grp_reset |=> subsystem_id_o == SUBSYS_ID_RESET)
    else $error("group reset left identifier");

  a_map_reset: assert property (
    grp_reset |=> ##1
      node_map_o.pin_count == 3'h1 && node_map_o.wl_count == 2'h0)
    else $error("group reset left layout");

  a_map_three_two: assert property (
    set_vendor && pay[4:0] == 5'h0b |=> ##1
      node_map_o.wl_first == 4'h8 && node_map_o.wl_count == 2'h2)
    else $error("three pins with two wireless misplaced");

  a_map_four_one: assert property (
    set_vendor && pay[4:0] == 5'h17 |=> ##1
      node_map_o.wl_first == 4'h9 && node_map_o.wl_count == 2'h1 &&
      node_map_o.pin_count == 3'h4)
    else $error("four pins with one wireless misplaced");

  a_map_four_pins: assert property (
    set_vendor && pay[4] && pay[0] |=> ##1
      node_map_o.pin_count == 3'h4 && node_map_o.any_map &&
      node_map_o.multistream == $past(pay[1], 2))
    else $error("four pin layout wrong");

  c_power_d0: cover property (set_power && pay[1:0] == 2'h0);
  c_vendor_full: cover property (set_vendor && pay[4:0] == 5'h1b);
  c_subsys_read: cover property (cmd_valid_i &&
    hit(cmd_i, dac_pkg::NODE_GROUP, dac_pkg::VERB_GET_SUBSYS0));
  c_group_reset: cover property (grp_reset);

endmodule

// ---- tb/dac_link_model.sv ----
// Link controller model that issues codec verbs and collects answers.
module dac_link_model
(
  input  wire logic         clk_i,       // Codec clock.
  output dac_pkg::dac_cmd_t cmd_o,       // Node, verb, payload.
  output logic              cmd_valid_o, // Verb strobe.
  input  wire logic         rsp_valid_i, // Answer strobe.
  input  wire logic [31:0]  rsp_data_i   // Answer word.
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus at time zero.
  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_o       = '0;
  end

  // One verb per call. The bus is inverted once idle, so a design that
  // samples outside the strobe sees junk instead of a friendly copy.
  task automatic issue(input logic [7:0] node, input logic [11:0] verb,
                       input logic [7:0] payload, output logic [31:0] data,
                       output bit ok);
    int n;
    ok   = 1'b0;
    data = '0;
    if (verb == dac_pkg::VERB_SET_POWER && ^payload[1:0])
      payload[1:0] = dac_pkg::PS_D3;
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_o       <= '{node: node, verb: verb, payload: payload};
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    cmd_o       <= ~cmd_o;
    for (n = 0; n < 4 && !ok; n++)
    begin
      #1;
      if (rsp_valid_i === 1'b1)
      begin
        data = rsp_data_i;
        ok   = 1'b1;
      end
      else
        @(posedge clk_i);
    end
  endtask
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the root and function group verb unit.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [15:0] MAKER = 16'h5a11;       // Arbitrary value.
  localparam logic [15:0] PART  = 16'h0b07;       // Arbitrary value.
  localparam logic [31:0] SUBSYS_RST = 32'h00c0_ffee;  // Arbitrary value.

  logic              clk_i;
  logic              rst_n_i;
  logic              cmd_valid;
  dac_pkg::dac_cmd_t cmd;
  logic              rsp_valid;
  logic [31:0]       rsp_data;
  dac_pkg::dac_map_t node_map;
  logic [1:0]        power_level;
  logic [5:0]        clock_select;
  logic [31:0]       subsystem_id;
  int                err_count;
  int                total_checks;

  // Free-running 100 MHz codec clock.
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  dac_verb_unit #(.MAKER_CODE(MAKER), .PART_CODE(PART),
                  .SUBSYS_ID_RESET(SUBSYS_RST))
  dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid),
       .cmd_i(cmd), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
       .node_map_o(node_map), .power_level_o(power_level),
       .clock_select_o(clock_select), .subsystem_id_o(subsystem_id));

  dac_link_model link (.clk_i(clk_i), .cmd_o(cmd), .cmd_valid_o(cmd_valid),
                       .rsp_valid_i(rsp_valid), .rsp_data_i(rsp_data));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // A lost answer strobe ends the run rather than hanging it.
  task automatic xfer(input logic [7:0] nd, input logic [11:0] vb,
                      input logic [7:0] pl, output logic [31:0] d);
    bit ok;
    link.issue(nd, vb, pl, d, ok);
    if (!ok)
    begin
      err_count++;
      $display("mismatch answer strobe expected 1 seen 0");
      complete_run();
    end
  endtask

  task automatic get(input string s, input logic [7:0] nd,
                     input logic [11:0] vb, input logic [7:0] pl,
                     input logic [31:0] exp);
    logic [31:0] d;
    xfer(nd, vb, pl, d);
    chk(s, exp, d);
  endtask

  function automatic logic [12:0] mk(input logic [2:0] pins,
      input logic [1:0] wn, input logic [3:0] wf, input logic ms, am);
    return {pins, 2'h0, wn, wf, ms, am};
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic reset_values();
    logic [31:0] want;
    want = 32'(mk(3'h1, 2'h0, 4'h6, 1'b0, 1'b0));
    chk("level", 32'h3, 32'(power_level));
    chk("clock", 32'h10, 32'(clock_select));
    chk("subsys", SUBSYS_RST, subsystem_id);
    chk("map", want, 32'(node_map));
  endtask

  task automatic root_params();
    get("ident", 8'h0, 12'hf00, 8'h00, {MAKER, PART});
    get("rev", 8'h0, 12'hf00, 8'h02, 32'h0010_0000);
    get("rchild", 8'h0, 12'hf00, 8'h04, 32'h0000_0001);
    get("rpower", 8'h0, 12'hf05, 8'h00, 32'h0);
    get("rtype", 8'h0, 12'hf00, 8'h05, 32'h0);
  endtask

  task automatic group_params();
    get("gchild", 8'h1, 12'hf00, 8'h04, 32'h0003_0007);
    get("gtype", 8'h1, 12'hf00, 8'h05, 32'h0000_0001);
    get("gcap", 8'h1, 12'hf00, 8'h08, 32'h0);
    get("levels", 8'h1, 12'hf00, 8'h0f, 32'hc000_0009);
    get("link", 8'h1, 12'hf00, 8'h16, 32'h0000_0018);
    get("gbad", 8'h1, 12'hf00, 8'h03, 32'h0);
  endtask

  task automatic power_levels();
    logic [31:0] d;
    xfer(8'h1, 12'h705, 8'h00, d);
    chk("setans", 32'h0, d);
    chk("level", 32'h0, 32'(power_level));
    get("report", 8'h1, 12'hf05, 8'h00, 32'h0000_0200);
    xfer(8'h1, 12'h705, 8'h03, d);
    get("report", 8'h1, 12'hf05, 8'h00, 32'h0000_0233);
  endtask

  task automatic subsys_bytes();
    logic [31:0] d;
    for (int i = 0; i < 4; i++)
      xfer(8'h1, 12'h720 + 12'(i), 8'h11 * 8'(i + 1), d);
    chk("subsys", 32'h4433_2211, subsystem_id);
    for (int i = 0; i < 4; i++)
      get("subsysrd", 8'h1, 12'hf20 + 12'(i), 8'h0, 32'h4433_2211);
  endtask

  // Every select bit, including the reserved low rates, reads back one-hot.
  task automatic clock_select_all();
    logic [31:0] d;
    get("clk", 8'h1, 12'hf37, 8'h0, 32'h10);
    for (int b = 0; b < 6; b++)
    begin
      xfer(8'h1, 12'h724, 8'h1 << b, d);
      get("clk", 8'h1, 12'hf24, 8'h0, 32'h1 << b);
      get("clkalt", 8'h1, 12'hf37, 8'h0, 32'h1 << b);
    end
  endtask

  // The layout follows the stored control one cycle later, two cycles after the set verb.
  task automatic vendor_map();
    logic [7:0]  ctl [7] = '{8'h01, 8'h11, 8'h13, 8'h07, 8'h0b, 8'h17, 8'h1b};
    logic [31:0] d;
    logic [31:0] want;
    logic [2:0]  p;
    foreach (ctl[i])
    begin
      p = ctl[i][4] ? 3'h4 : 3'h3;
      // Three pins alone stay 1:1; multistream or a fourth pin opens mapping.
      want = 32'(mk(p, ctl[i][3:2], 4'h5 + 4'(p), ctl[i][1],
                    ctl[i][1] | ctl[i][4]));
      xfer(8'h0b, 12'h781, ctl[i], d);
      @(posedge clk_i);
      #1;
      chk("map", want, 32'(node_map));
      get("vend", 8'h0b, 12'hf81, 8'h0, 32'(ctl[i]));
    end
  endtask

  task automatic group_reset();
    logic [31:0] d;
    xfer(8'h1, 12'h705, 8'h00, d);
    xfer(8'h1, 12'h720, 8'h55, d);
    xfer(8'h1, 12'h724, 8'h01, d);
    xfer(8'h1, 12'h7ff, 8'h00, d);
    @(posedge clk_i);
    #1;
    reset_values();
    get("report", 8'h1, 12'hf05, 8'h00, 32'h0000_0233);
    get("vend", 8'h0b, 12'hf81, 8'h0, 32'h0);
  endtask

  // Main sequence: reset held sixteen cycles, then each scenario in turn.
  initial
  begin
    err_count    = 0;
    total_checks = 0;
    rst_n_i      = 1'b0;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
    reset_values();
    root_params();
    group_params();
    power_levels();
    subsys_bytes();
    clock_select_all();
    vendor_map();
    group_reset();
    complete_run();
  end
endmodule
